// ---- design/erx_sysif.sv ----
/*
 * receive system interface of one framer: parity or forced bit in the first
 * bit of timeslot zero, timeslot and bit offset from the frame reference.
 * assumes the system clock and common frame pulses arrive as pins sampled by
 * clk, and the line data and signaling come from logic on clk, one bit per
 * bit_take_q pulse.
 */
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "erx_regs.svh"

module erx_sysif
   import erx_pkg::*;
#(
   parameter int ADDR_W = 3
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // system side pins
   input  wire logic              sys_clk_pin,
   input  wire logic              common_frame_pulse_in,
   input  wire logic              mux_common_frame_pulse_in,
   input  wire logic              any_framer_frame_pulse_ref_mode_in,
   output erx_sys_out_t           sys_out_q,
   output logic                   mux_rx_sys_data_out,
   output logic                   mux_frame_sync_out,
   output logic                   mux_signaling_out,
   // internal line side
   input  wire logic              line_data_in,
   input  wire logic              line_sig_in,
   output logic                   bit_take_q,
   output logic                   frame_start_q
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (ADDR_W < 3) begin : g_bad_addr
      $error("erx_sysif: ADDR_W must be at least 3");
   end

   // ---------------------------------------------------------------
   // registers written by software, their shadow and status capture
   // ---------------------------------------------------------------
   logic [7:0] par_q;
   logic [7:0] edge_q;
   logic [7:0] frame_q;
   logic [7:0] tsoff_q;
   logic [7:0] boff_q;
   erx_cfg_t   cfg_q;
   logic       par_last_q;
   logic [7:0] bit_idx_q;

   // register writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         par_q   <= `ERX_RST_REG;
         edge_q  <= `ERX_RST_REG;
         frame_q <= `ERX_RST_REG;
         tsoff_q <= `ERX_RST_REG;
         boff_q  <= `ERX_RST_REG;
      end else if (reg_wr) begin
         case (reg_addr[2:0])
            `ERX_OFS_PARITY: par_q   <= reg_wdata;
            `ERX_OFS_EDGE:   edge_q  <= reg_wdata;
            `ERX_OFS_FRAME:  frame_q <= reg_wdata;
            `ERX_OFS_TSOFF:  tsoff_q <= {1'b0, reg_wdata[6:0]};
            `ERX_OFS_BOFF:   boff_q  <= {4'h0, reg_wdata[3:0]};
            default: ;
         endcase
      end
   end

   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (sys_rst || !reg_rd || (reg_addr > ADDR_W'(`ERX_OFS_STATUS))) begin
         reg_rdata <= 8'h00;
      end else begin
         case (reg_addr[2:0])
            `ERX_OFS_PARITY: reg_rdata <= par_q;
            `ERX_OFS_EDGE:   reg_rdata <= edge_q;
            `ERX_OFS_FRAME:  reg_rdata <= frame_q;
            `ERX_OFS_TSOFF:  reg_rdata <= tsoff_q;
            `ERX_OFS_BOFF:   reg_rdata <= boff_q;
            `ERX_OFS_STATUS: reg_rdata <= {par_last_q, 2'h0, bit_idx_q[7:3]};
            default:         reg_rdata <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pin synchronisers, three stages, change taken when 2 and 3 agree
   // ---------------------------------------------------------------
   logic [2:0] sck_s;
   logic [2:0] cfp_s;
   logic [2:0] mcfp_s;
   logic       sck_f_q;
   logic       cfp_f_q;
   logic       mcfp_f_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sck_s  <= 3'h0;
         cfp_s  <= 3'h0;
         mcfp_s <= 3'h0;
      end else begin
         sck_s  <= {sck_s[1:0], sys_clk_pin};
         cfp_s  <= {cfp_s[1:0], common_frame_pulse_in};
         mcfp_s <= {mcfp_s[1:0], mux_common_frame_pulse_in};
      end
   end

   // filtered levels
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sck_f_q  <= 1'b0;
         cfp_f_q  <= 1'b0;
         mcfp_f_q <= 1'b0;
      end else begin
         if (sck_s[1] == sck_s[2])
            sck_f_q <= sck_s[2];
         if (cfp_s[1] == cfp_s[2])
            cfp_f_q <= cfp_s[2];
         if (mcfp_s[1] == mcfp_s[2])
            mcfp_f_q <= mcfp_s[2];
      end
   end

   // ---------------------------------------------------------------
   // system clock edges and frame reference
   // ---------------------------------------------------------------
   logic sck_d1_q;
   logic ref_pend_q;
   logic ref_d1_q;
   logic sck_rise;
   logic sck_fall;
   logic sck_edge;
   logic fe_edge;
   logic fp_eff;
   logic ref_lvl;

   assign sck_rise = sck_f_q & ~sck_d1_q;
   assign sck_fall = ~sck_f_q & sck_d1_q;
   assign sck_edge = sck_rise | sck_fall;
   assign fe_edge  = cfg_q.fe ? sck_fall : sck_rise;
   assign fp_eff   = cfg_q.mux ? (any_framer_frame_pulse_ref_mode_in | cfg_q.frame_pulse_ref_mode) : cfg_q.frame_pulse_ref_mode;
   assign ref_lvl  = cfg_q.mux ? mcfp_f_q : cfp_f_q;

   // latch pulse, take it on frame edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sck_d1_q   <= 1'b0;
         ref_d1_q   <= 1'b0;
         ref_pend_q <= 1'b0;
      end else begin
         sck_d1_q <= sck_f_q;
         ref_d1_q <= ref_lvl;
         if (ref_lvl && !ref_d1_q)
            ref_pend_q <= 1'b1;
         else if (fe_edge)
            ref_pend_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // offset arithmetic
   // ---------------------------------------------------------------
   logic [9:0]  epb;
   logic [9:0]  mask;
   logic        boff_on;
   logic [9:0]  transmit_clock_edge_count;
   logic [12:0] start_raw;
   logic [9:0]  data_start;
   logic        special;
   logic [9:0]  lead;
   logic [9:0]  fs_pos;
   logic        edges_same;

   assign edges_same = (cfg_q.fe == cfg_q.de);
   assign epb        = cfg_q.dbl ? `ERX_EPB_DOUBLE : `ERX_EPB_SINGLE;
   assign mask       = cfg_q.dbl ? `ERX_MASK_DOUBLE : `ERX_MASK_SINGLE;
   // no bit offset at double rate
   assign boff_on    = cfg_q.bit_offset_en & ~cfg_q.dbl;
   assign transmit_clock_edge_count = (fp_eff ? `ERX_CET_BASE_CP : `ERX_CET_BASE_FS)
              - {9'h000, ~edges_same} + {6'h00, cfg_q.boff, 1'b0};
   assign start_raw  = 13'({cfg_q.tsoff, 3'h0}) * 13'(epb) + (boff_on ? 13'(transmit_clock_edge_count) : 13'h0000);
   assign data_start = start_raw[9:0] & mask;
   assign special    = cfg_q.sigmf & cfg_q.alt;
   // one or one and a half bits
   assign lead       = edges_same ? epb : (epb + {1'b0, epb[9:1]});
   always_comb begin
      if (special && (fp_eff || !boff_on))
         fs_pos = (data_start - lead) & mask;
      else if (fp_eff)
         fs_pos = data_start;
      else
         fs_pos = 10'h000;
   end

   // ---------------------------------------------------------------
   // edge counter, shadow load at the data start
   // ---------------------------------------------------------------
   logic [9:0] cnt_q;
   logic       tick_q;

   // count every system clock edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q  <= 10'h000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= sck_edge;
         if (fe_edge && ref_pend_q && fp_eff)
            cnt_q <= 10'h000;
         else if (sck_edge)
            cnt_q <= (cnt_q + 10'h001) & mask;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_q <= '0;
      end else if (tick_q && (((cnt_q - data_start) & mask) == 10'h000)) begin
         cfg_q <= '{par_odd: par_q[`ERX_B_PAR_ODD], par_en: par_q[`ERX_B_PAR_EN],
                    fix_en: par_q[`ERX_B_FIX_EN], fix_val: par_q[`ERX_B_FIX_VAL],
                    par_ext: par_q[`ERX_B_PAR_EXT], frac_fbit: par_q[`ERX_B_FRAC_FBIT],
                    de: edge_q[`ERX_B_DE], fe: edge_q[`ERX_B_FE], dbl: edge_q[`ERX_B_DBL],
                    mux: edge_q[`ERX_B_MUX], frame_pulse_ref_mode: frame_q[`ERX_B_FRAME_PULSE_REF_MODE],
                    sigmf: frame_q[`ERX_B_SIGMF], alt: frame_q[`ERX_B_ALT],
                    tsoff: tsoff_q[6:0], bit_offset_en: boff_q[`ERX_B_BIT_OFFSET_EN],
                    boff: boff_q[2:0]};
      end
   end

   // ---------------------------------------------------------------
   // bit stream, parity and frame sync
   // ---------------------------------------------------------------
   logic [9:0] rel;
   logic [9:0] rel_fs;
   logic       new_bit;
   logic [7:0] bit_idx;
   logic       par_acc_q;
   logic       par_res;
   logic       first_bit;

   assign rel     = (cnt_q - data_start) & mask;
   assign rel_fs  = (cnt_q - fs_pos) & mask;
   assign new_bit = tick_q && ((rel & (epb - 10'h001)) == 10'h000);
   assign bit_idx = cfg_q.dbl ? rel[9:2] : rel[8:1];
   assign par_res = par_acc_q ^ cfg_q.par_odd;

   always_comb begin
      if (cfg_q.par_en && !cfg_q.frac_fbit)
         first_bit = par_res;
      else if (cfg_q.fix_en)
         first_bit = cfg_q.fix_val;
      else
         first_bit = line_data_in;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         par_acc_q  <= 1'b0;
         par_last_q <= 1'b0;
      end else if (new_bit) begin
         if (bit_idx == 8'h00) begin
            par_last_q <= par_res;
            par_acc_q  <= par_q[`ERX_B_PAR_EXT] & line_data_in; // shadow loads on this tick
         end else begin
            par_acc_q  <= par_acc_q ^ line_data_in;
         end
      end
   end

   // data and signaling follow the data start
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sys_out_q.data <= 1'b0;
         sys_out_q.sig  <= 1'b0;
         bit_idx_q      <= 8'h00;
         bit_take_q     <= 1'b0;
         frame_start_q  <= 1'b0;
      end else begin
         bit_take_q    <= new_bit;
         frame_start_q <= new_bit && (bit_idx == 8'h00);
         if (new_bit) begin
            sys_out_q.data <= (bit_idx == 8'h00) ? first_bit : line_data_in;
            sys_out_q.sig  <= line_sig_in;
            bit_idx_q      <= bit_idx;
         end
      end
   end

   // frame sync one bit wide from its position
   always_ff @(posedge clk) begin
      if (sys_rst)
         sys_out_q.fsync <= 1'b0;
      else if (tick_q)
         sys_out_q.fsync <= (rel_fs < epb);
   end

   // multiplexed bus copies
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mux_rx_sys_data_out <= 1'b0;
         mux_frame_sync_out  <= 1'b0;
         mux_signaling_out   <= 1'b0;
      end else begin
         mux_rx_sys_data_out <= cfg_q.mux & sys_out_q.data;
         mux_frame_sync_out  <= cfg_q.mux & sys_out_q.fsync;
         mux_signaling_out   <= cfg_q.mux & sys_out_q.sig;
      end
   end

endmodule

// ---- include/erx_pkg.sv ----
/*
 * types of the receive system interface parity and offset block.
 * assumes erx_regs.svh holds all numeric constants.
 */
package erx_pkg;

   // ---------------------------------------------------------------
   // configuration held in shadow at the frame boundary
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       par_odd;
      logic       par_en;
      logic       fix_en;
      logic       fix_val;
      logic       par_ext;
      logic       frac_fbit;
      logic       de;
      logic       fe;
      logic       dbl;
      logic       mux;
      logic       frame_pulse_ref_mode;
      logic       sigmf;
      logic       alt;
      logic [6:0] tsoff;
      logic       bit_offset_en;
      logic [2:0] boff;
   } erx_cfg_t;

   // ---------------------------------------------------------------
   // system-side outputs travelling together
   // ---------------------------------------------------------------
   typedef struct packed {
      logic data;
      logic fsync;
      logic sig;
   } erx_sys_out_t;

endpackage

// ---- include/erx_regs.svh ----
/*
 * register offsets, field positions, reset values and timing counts of the
 * receive system interface parity and offset block.
 * assumes byte-wide registers on a plain strobe port, one framer per instance.
 */
// How it works
// - parity of previous frame replaces first bit of timeslot zero
// - parity insertion blocked only in clock-slave fractional mode with F-bit
// - parity type bit picks even or odd parity
// - extent bit says whether first timeslot-zero bit joins the parity
// - forced-bit enable drives first timeslot-zero bit to forced value
// - parity insertion wins over forced bit when both are enabled
// - bit offset ignored while double-rate system clock is selected
// - clock slave: reference is common pulse (mode 1) or own frame sync
// - multiplexed: any framer in mode 1 selects multiplexed common pulse
// - timeslot offset is a seven-bit binary count
// - bit offset applies only when enabled; three-bit code in clock edges
// - common-pulse reference: count from pulse edge, frame sync follows data
// - frame-sync reference: count from frame sync edge, signaling follows data
// - mode 0 edge count is 4 plus twice code, or 3 when edges differ
// - mode 1 edge count is 2 plus twice code, or 1 when edges differ
// - multiframe and alternate selects both set give frame sync bit offset
// - then without offset or in mode 1, lead is 1 or 1.5 bits
// - frame edge select times pulses, data edge select times data
`ifndef ERX_REGS_SVH
`define ERX_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ERX_OFS_PARITY   3'h0
`define ERX_OFS_EDGE     3'h1
`define ERX_OFS_FRAME    3'h2
`define ERX_OFS_TSOFF    3'h3
`define ERX_OFS_BOFF     3'h4
`define ERX_OFS_STATUS   3'h5

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ERX_B_PAR_ODD    7
`define ERX_B_PAR_EN     6
`define ERX_B_FIX_EN     5
`define ERX_B_FIX_VAL    4
`define ERX_B_PAR_EXT    3
`define ERX_B_FRAC_FBIT  0
`define ERX_B_DE         4
`define ERX_B_FE         3
`define ERX_B_DBL        2
`define ERX_B_MUX        0
`define ERX_B_FRAME_PULSE_REF_MODE     5
`define ERX_B_SIGMF      2
`define ERX_B_ALT        0
`define ERX_B_BIT_OFFSET_EN    3

// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
`define ERX_RST_REG      8'h00
`define ERX_EPB_SINGLE   10'h002
`define ERX_EPB_DOUBLE   10'h004
`define ERX_CET_BASE_FS  10'h004
`define ERX_CET_BASE_CP  10'h002
`define ERX_MASK_SINGLE  10'h1FF
`define ERX_MASK_DOUBLE  10'h3FF

`endif

// ---- tb/erx_backplane_model.sv ----
/*
 * backplane model: free running system clock and common frame pulse.
 * assumes clk is the fast clock the pins are timed from.
 */
`timescale 1ns/1ps

module erx_backplane_model #(
   parameter int H     = 5,
   parameter int EDGES = 512
) (
   // timing source
   input wire logic clk,
   // backplane pins
   output logic     sys_clk_pin,
   output logic     frame_pulse
);
   int div    = 0;
   int edge_n = 0;

   initial begin
      sys_clk_pin = 1'b0;
      frame_pulse = 1'b0;
   end

   // ---------------------------------------------------------------
   // clock edges every H cycles, pulse one bit wide per frame
   // ---------------------------------------------------------------
   // pulse active edge
   always @(posedge clk) begin
      if (div == H - 1) begin
         div <= 0;
         edge_n <= (edge_n == EDGES - 1) ? 0 : edge_n + 1;
         sys_clk_pin <= ~sys_clk_pin;
         frame_pulse <= (edge_n == EDGES - 1) || (edge_n == 0);
      end else begin
         div <= div + 1;
      end
   end
endmodule

// ---- tb/erx_sysif_bench.sv ----
/*
 * self-checking bench of the parity and offset block.
 * assumes erx_backplane_model drives the system pins.
 */
`timescale 1ns/1ps

module erx_sysif_bench
   import erx_pkg::*;
;
   localparam int H = 4;
   localparam logic [7:0] MK [5] = '{8'hF9, 8'h1D, 8'h25, 8'h7F, 8'h0F};
   // rows: parity, edge, frame, tsoff, boff, kind, expected
   // kind 0 fixed bit, 1 offset in edges, 2 latency base, 3 parity {odd, extent}
   localparam logic [55:0] ROWS [16] = '{
      56'h20_00_00_00_00_00_00,
      56'h40_00_00_00_00_03_00,
      56'hC0_00_00_00_00_03_02,
      56'h48_00_00_00_00_03_01,
      56'hE8_00_00_00_00_03_03,
      56'h71_00_00_00_00_00_01,
      56'h00_00_00_01_07_01_10,
      56'h00_00_00_02_0F_01_32,
      56'h00_08_00_00_08_01_03,
      56'h00_05_00_01_0D_01_20,
      56'h00_00_05_00_00_01_02,
      56'h00_10_05_00_00_01_03,
      56'h00_00_20_00_00_02_00,
      56'h00_00_20_01_0B_01_18,
      56'h00_10_20_00_08_01_01,
      56'h00_01_10_01_0B_01_18
   };
   logic             clk;
   logic             sys_rst;
   logic [2:0]       reg_addr;
   logic [7:0]       reg_wdata;
   logic             reg_wr;
   logic             reg_rd;
   logic [7:0]       reg_rdata;
   logic             sys_clk_pin;
   logic             cfp;
   erx_sys_out_t     sys_out_q;
   logic             bit_take_q;
   logic             frame_start_q;
   logic             fpm;
   logic             oth     = 1'b0;
   logic             ld      = 1'b0;
   logic             sg      = 1'b0;
   logic             b0      = 1'b0;
   logic             pacc    = 1'b0;
   logic             pexp;
   logic [31:0]      lv;
   logic             rf;
   logic             rf_d    = 1'b0;
   logic             rd_seen = 1'b0;
   logic [31:0]      s       = 32'h0000_0028;
   logic [55:0]      r;
   logic [17:0]      ev;
   logic [31:0]      v;
   logic [7:0]       rd_q[$];
   logic [17:0]      ev_q[$];
   int               cnt     = 0;
   int               base    = 0;
   int               n_fail  = 0;
   int               tests_run = 0;
   int               i;

   erx_sysif u_erx_sysif (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_clk_pin(sys_clk_pin), .common_frame_pulse_in(cfp),
      .mux_common_frame_pulse_in(cfp), .any_framer_frame_pulse_ref_mode_in(oth), .sys_out_q(sys_out_q),
      .mux_rx_sys_data_out(), .mux_frame_sync_out(), .mux_signaling_out(),
      .line_data_in(ld), .line_sig_in(sg), .bit_take_q(bit_take_q), .frame_start_q(frame_start_q)
   );

   erx_backplane_model #(.H(H), .EDGES(512)) u_erx_backplane_model (
      .clk(clk), .sys_clk_pin(sys_clk_pin), .frame_pulse(cfp)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] sn);
      tests_run++;
      if (sn !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, sn);
      end
   endtask

   // one bus cycle, a read notes its expected data
   task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      if (!w) rd_q.push_back(e);
      @(posedge clk);
   endtask

   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask

   // wait for the next frame start, bounded
   task automatic wait_fs();
      int k;
      k = 0;
      @(posedge clk);
      while (frame_start_q !== 1'b1 && k < 6000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 6000) n_fail++;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog, observers
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      summarize();
   end

   // cycles since the reference pulse rose
   always @(posedge clk) begin
      rd_seen <= reg_rd;
      rf = fpm ? cfp : sys_out_q.fsync;
      rf_d <= rf;
      cnt <= (rf && !rf_d) ? 1 : cnt + 1;
   end

   // fresh random line bits after each take, parity of the frame kept beside
   always @(posedge clk) begin
      if (bit_take_q === 1'b1) begin
         if (frame_start_q === 1'b1) begin
            b0   <= ld;
            pacc <= 1'b0;
         end else begin
            pacc <= pacc ^ ld;
         end
         lv = rnd();
         ld <= lv[0];
         sg <= lv[1];
      end
   end

   // compare oldest note with what appears
   always @(negedge clk) begin
      if (rd_seen) chk("reg_rdata", {8'h00, rd_q.pop_front()}, {8'h00, reg_rdata});
      if (frame_start_q === 1'b1 && ev_q.size() > 0) begin
         ev = ev_q.pop_front();
         pexp = pacc ^ (ev[0] & b0) ^ ev[1];
         if (ev[17:16] == 2'h0) chk("first bit", ev[15:0], {15'h0000, sys_out_q.data});
         else if (ev[17:16] == 2'h1) chk("offset", ev[15:0], 16'(cnt - base));
         else if (ev[17:16] == 2'h3) chk("parity bit", {15'h0000, pexp}, {15'h0000, sys_out_q.data});
         else base = cnt; // pin to frame start latency at zero offset
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      fpm = 1'b0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 8; i++) if (i != 5) bus(1'b0, 3'(i), 8'h00, 8'h00);
      for (i = 0; i < 5; i++) begin
         v = rnd();
         bus(1'b1, 3'(i), (i < 3) ? (v[7:0] & MK[i]) : v[7:0], 8'h00);
         bus(1'b0, 3'(i), 8'h00, v[7:0] & MK[i]);
      end
      bus(1'b1, 3'h6, 8'hFF, 8'h00);
      bus(1'b0, 3'h6, 8'h00, 8'h00);
      idle();
      $display("register test done");
      wait_fs();
      for (i = 0; i < 16; i++) begin
         r = ROWS[i];
         fpm = r[37] | r[36];
         oth <= r[36];
         bus(1'b1, 3'h0, r[55:48], 8'h00);
         bus(1'b1, 3'h1, r[47:40], 8'h00);
         bus(1'b1, 3'h2, r[39:32], 8'h00);
         bus(1'b1, 3'h3, r[31:24], 8'h00);
         bus(1'b1, 3'h4, r[23:16], 8'h00);
         idle();
         wait_fs();
         ev_q.push_back({r[9:8], (r[9:8] == 2'h1) ? 16'(r[7:0] * H) : {8'h00, r[7:0]}});
         wait_fs();
         $display("row %0d done", i);
      end
      repeat (3) @(posedge clk);
      summarize();
   end
endmodule

// ---- tb/erx_sysif_monitor.sv ----
/*
 * port checker of the parity and offset block.
 * assumes it is bound onto every erx_sysif instance.
 */
`timescale 1ns/1ps

module erx_sysif_monitor
   import erx_pkg::*;
#(
   parameter int ADDR_W = 3
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              sys_rst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   // system side
   input wire erx_sys_out_t      sys_out_q,
   input wire logic              mux_rx_sys_data_out,
   input wire logic              mux_frame_sync_out,
   input wire logic              mux_signaling_out,
   input wire logic              bit_take_q,
   input wire logic              frame_start_q
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_tsoff_width: assert property (
      reg_rd && reg_addr == 3'h3 |=> reg_rdata[7] == 1'b0) else $error("timeslot offset bit 7 set");
   a_tsoff_readback: assert property (
      reg_wr && reg_addr == 3'h3 ##1 reg_rd && reg_addr == 3'h3
      |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)}) else $error("timeslot offset readback");
   a_boff_width: assert property (
      reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:4] == 4'h0) else $error("bit offset upper bits set");
   a_boff_readback: assert property (
      reg_wr && reg_addr == 3'h4 ##1 reg_rd && reg_addr == 3'h4
      |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)}) else $error("bit offset readback");
   a_start_on_take: assert property (
      frame_start_q |-> bit_take_q) else $error("frame start without bit take");
   a_take_spacing: assert property (
      bit_take_q |=> !bit_take_q ##1 !bit_take_q) else $error("bit takes too close");
   a_data_on_take: assert property (
      $changed(sys_out_q.data) |-> bit_take_q) else $error("data moved off a bit take");
   a_sig_aligned: assert property (
      $changed(sys_out_q.sig) |-> bit_take_q) else $error("signaling not aligned to data");
   a_mux_data_copy: assert property (
      mux_rx_sys_data_out |-> $past(sys_out_q.data)) else $error("mux data not a copy");
   a_mux_fsync_copy: assert property (
      mux_frame_sync_out |-> $past(sys_out_q.fsync)) else $error("mux frame sync not a copy");
   a_mux_sig_copy: assert property (
      mux_signaling_out |-> $past(sys_out_q.sig)) else $error("mux signaling not a copy");
endmodule

bind erx_sysif erx_sysif_monitor #(.ADDR_W(ADDR_W)) u_erx_sysif_monitor (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_out_q(sys_out_q),
   .mux_rx_sys_data_out(mux_rx_sys_data_out), .mux_frame_sync_out(mux_frame_sync_out),
   .mux_signaling_out(mux_signaling_out),
   .bit_take_q(bit_take_q), .frame_start_q(frame_start_q)
);
